// ===== logic/ccfc_consts.svh
//----------------------------------------------------------------------
// Purpose: Word offsets, field positions and decode constants
// Assumes: 16-bit calibration words, word-addressed
// Notes:   Definitions only
//----------------------------------------------------------------------
`ifndef CCFC_CONSTS_SVH
`define CCFC_CONSTS_SVH

//----------------------------------------------------------------------
// Word offsets
//----------------------------------------------------------------------
`define CCFC_W_SENS   8'h0D
`define CCFC_W_TC     8'h0E
`define CCFC_W_SOT    8'h0F
`define CCFC_W_TOFS   8'h10
`define CCFC_W_TGAIN  8'h11
`define CCFC_W_CFG1   8'h12

//----------------------------------------------------------------------
// Field positions and reset values
//----------------------------------------------------------------------
`define CCFC_HI_B     15:8
`define CCFC_LO_B     7:0
`define CCFC_SIGN_B   23
`define CCFC_COEF_W   24
`define CCFC_RST_WORD 16'h0000
`define CCFC_RST_BYTE 8'h00
`define CCFC_G1_F     2:0
`define CCFC_G2_F     5:3
`define CCFC_POL_B    6
`define CCFC_RES_F    10:7
`define CCFC_ABS_B    11

//----------------------------------------------------------------------
// Decode tables
//----------------------------------------------------------------------
`define CCFC_G1_TAB   {8'h78, 8'h50, 8'h3C, 8'h28, 8'h1E, 8'h14, 8'h0C, 8'h06}
`define CCFC_G2_BASE  5'h0B
`define CCFC_RES_BASE 5'h0C
`define CCFC_RES_MAX  4'h6
`define CCFC_RES_TOP  5'h12
`define CCFC_G1_RST   8'h06

`endif

// ===== logic/ccfc_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared types of the calibration coefficient block
// Assumes: Nothing beyond the constants header
// Notes:   Types only
//----------------------------------------------------------------------
package ccfc_pkg;

   typedef logic [15:0] ccfc_word_t;
   typedef logic [23:0] ccfc_coef_t;

   typedef enum logic
   {
      CCFC_POL_POS = 1'b0,
      CCFC_POL_NEG = 1'b1
   } ccfc_pol_t;

endpackage : ccfc_pkg

// ===== logic/ccfc_top.sv
//----------------------------------------------------------------------
// Purpose: Hold coefficient upper bytes and setup word 1, join them with
//          externally held low words, decode the front-end setup
// Assumes: Word port comes from the serial command engine, one word/cycle
// Notes:   Outputs lag a word write by two clocks (store, then assemble)
//----------------------------------------------------------------------
`include "ccfc_consts.svh"

// Summary of operation
// - Offset: word 0D high byte over word 03
// - Gain: word 0D low byte over word 04
// - Offset slope: word 0E low over 06
// - Gain slope: word 0E high over 05
// - Gain slope quadratic: 0F low over 08
// - Offset slope quadratic: 0F high over 07
// - Temperature offset: word 10 low over 0A
// - Readout quadratic: word 10 high over 09
// - Temperature quadratic: word 11 low over 0C
// - Temperature gain unsigned: 11 high over 0B
// - Bits 2:0 pick first front_amplifier gain
// - Bits 5:3 pick second gain 1.1-1.8
// - Bit 6 inverts chopper polarity
// - Bits 10:7 pick 12 to 18 bits
// - Bit 11 grounds negative input, absolute mode
// - Stored words read zero after reset; decoded gains reset to 06 and 0B, resolution to 12 bits
module ccfc_top
   import ccfc_pkg::*;
#(
   parameter int AW = 8,
   parameter int IW = 26
)
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] addr,
   input  wire ccfc_word_t    wdata,
   output ccfc_word_t         rdata,
   output logic               rvalid,
   input  wire ccfc_word_t    lo_word_03,
   input  wire ccfc_word_t    lo_word_04,
   input  wire ccfc_word_t    lo_word_05,
   input  wire ccfc_word_t    lo_word_06,
   input  wire ccfc_word_t    lo_word_07,
   input  wire ccfc_word_t    lo_word_08,
   input  wire ccfc_word_t    lo_word_09,
   input  wire ccfc_word_t    lo_word_0a,
   input  wire ccfc_word_t    lo_word_0b,
   input  wire ccfc_word_t    lo_word_0c,
   output logic [IW-1:0]      offset_coef,
   output logic [IW-1:0]      gain_coef,
   output logic [IW-1:0]      zero_slope_coef,
   output logic [IW-1:0]      gain_slope_coef,
   output logic [IW-1:0]      gain_slope_quadratic,
   output logic [IW-1:0]      zero_slope_quadratic,
   output logic [IW-1:0]      temp_offset_coef,
   output logic [IW-1:0]      readout_quadratic,
   output logic [IW-1:0]      temperature_quadratic,
   output logic [IW-1:0]      temp_gain_abs,
   output logic [7:0]         front_amplifier_first_gain,
   output logic [4:0]         front_amplifier_second_gain,
   output ccfc_pol_t          chopper_polarity,
   output logic [4:0]         adc_res_bits,
   output logic               single_ended_input_select,
   output logic               negative_input_to_ground,
   output logic               cfg_error,
   input  wire logic          conv_req,
   output logic               conv_start
);

   //-------------------------------------------------------------------
   // Stored words
   //-------------------------------------------------------------------
   ccfc_word_t  sens_hi_q;
   ccfc_word_t  tc_hi_q;
   ccfc_word_t  sot_hi_q;
   ccfc_word_t  tofs_hi_q;
   ccfc_word_t  tgain_hi_q;
   ccfc_word_t  setup_q;
   ccfc_coef_t  off_q;
   ccfc_coef_t  gain_q;
   ccfc_coef_t  tco_q;
   ccfc_coef_t  tcg_q;
   ccfc_coef_t  gain_slope_quadratic_q;
   ccfc_coef_t  zero_slope_quadratic_q;
   ccfc_coef_t  toff_q;
   ccfc_coef_t  readout_quadratic_q;
   ccfc_coef_t  temperature_quadratic_q;
   ccfc_coef_t  tgain_q;
   logic [63:0] g1_tab;

   assign g1_tab = `CCFC_G1_TAB;

   // Writes land whole-word; every field of setup word 1 is kept so the
   // fields decoded elsewhere see what software wrote
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sens_hi_q  <= `CCFC_RST_WORD;
         tc_hi_q    <= `CCFC_RST_WORD;
         sot_hi_q   <= `CCFC_RST_WORD;
         tofs_hi_q  <= `CCFC_RST_WORD;
         tgain_hi_q <= `CCFC_RST_WORD;
         setup_q    <= `CCFC_RST_WORD;
      end
      else if (wr_en)
      begin
         if (addr == `CCFC_W_SENS)  sens_hi_q  <= wdata;
         if (addr == `CCFC_W_TC)    tc_hi_q    <= wdata;
         if (addr == `CCFC_W_SOT)   sot_hi_q   <= wdata;
         if (addr == `CCFC_W_TOFS)  tofs_hi_q  <= wdata;
         if (addr == `CCFC_W_TGAIN) tgain_hi_q <= wdata;
         if (addr == `CCFC_W_CFG1)  setup_q    <= wdata;
      end
   end

   //-------------------------------------------------------------------
   // Read-back
   //-------------------------------------------------------------------
   // Unmapped offsets read as zero rather than stale data
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata  <= `CCFC_RST_WORD;
         rvalid <= 1'b0;
      end
      else
      begin
         rvalid <= rd_en;
         if (rd_en)
         begin
            unique case (addr)
               `CCFC_W_SENS:  rdata <= sens_hi_q;
               `CCFC_W_TC:    rdata <= tc_hi_q;
               `CCFC_W_SOT:   rdata <= sot_hi_q;
               `CCFC_W_TOFS:  rdata <= tofs_hi_q;
               `CCFC_W_TGAIN: rdata <= tgain_hi_q;
               `CCFC_W_CFG1:  rdata <= setup_q;
               default:       rdata <= `CCFC_RST_WORD;
            endcase
         end
      end
   end

   //-------------------------------------------------------------------
   // Coefficient assembly
   //-------------------------------------------------------------------
   // Registered so the arithmetic sees a whole coefficient change at once
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         off_q      <= '0;
         gain_q     <= '0;
         tco_q      <= '0;
         tcg_q      <= '0;
         gain_slope_quadratic_q  <= '0;
         zero_slope_quadratic_q  <= '0;
         toff_q     <= '0;
         readout_quadratic_q <= '0;
         temperature_quadratic_q    <= '0;
         tgain_q    <= '0;
      end
      else
      begin
         off_q      <= {sens_hi_q[`CCFC_HI_B], lo_word_03};
         gain_q     <= {sens_hi_q[`CCFC_LO_B], lo_word_04};
         tco_q      <= {tc_hi_q[`CCFC_LO_B], lo_word_06};
         tcg_q      <= {tc_hi_q[`CCFC_HI_B], lo_word_05};
         gain_slope_quadratic_q  <= {sot_hi_q[`CCFC_LO_B], lo_word_08};
         zero_slope_quadratic_q  <= {sot_hi_q[`CCFC_HI_B], lo_word_07};
         toff_q     <= {tofs_hi_q[`CCFC_LO_B], lo_word_0a};
         readout_quadratic_q <= {tofs_hi_q[`CCFC_HI_B], lo_word_09};
         temperature_quadratic_q    <= {tgain_hi_q[`CCFC_LO_B], lo_word_0c};
         tgain_q    <= {tgain_hi_q[`CCFC_HI_B], lo_word_0b};
      end
   end

   // Two's complement, bit 23 replicated upward
   assign offset_coef           = {{(IW-`CCFC_COEF_W){off_q[`CCFC_SIGN_B]}}, off_q};
   assign gain_coef             = {{(IW-`CCFC_COEF_W){gain_q[`CCFC_SIGN_B]}}, gain_q};
   assign zero_slope_coef       = {{(IW-`CCFC_COEF_W){tco_q[`CCFC_SIGN_B]}}, tco_q};
   assign gain_slope_coef       = {{(IW-`CCFC_COEF_W){tcg_q[`CCFC_SIGN_B]}}, tcg_q};
   assign gain_slope_quadratic  = {{(IW-`CCFC_COEF_W){gain_slope_quadratic_q[`CCFC_SIGN_B]}}, gain_slope_quadratic_q};
   assign zero_slope_quadratic  = {{(IW-`CCFC_COEF_W){zero_slope_quadratic_q[`CCFC_SIGN_B]}}, zero_slope_quadratic_q};
   assign temp_offset_coef      = {{(IW-`CCFC_COEF_W){toff_q[`CCFC_SIGN_B]}}, toff_q};
   assign readout_quadratic     = {{(IW-`CCFC_COEF_W){readout_quadratic_q[`CCFC_SIGN_B]}}, readout_quadratic_q};
   assign temperature_quadratic = {{(IW-`CCFC_COEF_W){temperature_quadratic_q[`CCFC_SIGN_B]}}, temperature_quadratic_q};
   // Magnitude only, so no sign to carry up
   assign temp_gain_abs         = {{(IW-`CCFC_COEF_W){1'b0}}, tgain_q};

   //-------------------------------------------------------------------
   // Front-end setup decode
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         front_amplifier_first_gain         <= `CCFC_G1_RST;
         front_amplifier_second_gain        <= `CCFC_G2_BASE;
         chopper_polarity          <= CCFC_POL_POS;
         adc_res_bits              <= `CCFC_RES_BASE;
         single_ended_input_select <= 1'b0;
         negative_input_to_ground  <= 1'b0;
         cfg_error                 <= 1'b0;
      end
      else
      begin
         front_amplifier_first_gain  <= g1_tab[{setup_q[`CCFC_G1_F], 3'h0} +: 8];
         front_amplifier_second_gain <= `CCFC_G2_BASE + {2'h0, setup_q[`CCFC_G2_F]};
         chopper_polarity   <= ccfc_pol_t'(setup_q[`CCFC_POL_B]);
         adc_res_bits       <= `CCFC_RES_BASE + {1'b0, setup_q[`CCFC_RES_F]};
         single_ended_input_select <= setup_q[`CCFC_ABS_B];
         negative_input_to_ground  <= setup_q[`CCFC_ABS_B];
         cfg_error          <= setup_q[`CCFC_RES_F] > `CCFC_RES_MAX;
      end
   end

   // A request under a bad resolution code is dropped, not queued
   assign conv_start = conv_req && !cfg_error;

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_offset_join: assert property (
      !$past(rst) |-> off_q == {$past(sens_hi_q[`CCFC_HI_B]), $past(lo_word_03)})
      else $error("offset coefficient misassembled");

   chk_gain_write: assert property (
      (wr_en && addr == `CCFC_W_SENS) ##1 !(wr_en && addr == `CCFC_W_SENS)
      |=> gain_q[23:16] == $past(wdata[`CCFC_LO_B], 2))
      else $error("gain upper byte not taken from write");

   chk_zslope_join: assert property (
      !$past(rst) |-> tco_q == {$past(tc_hi_q[`CCFC_LO_B]), $past(lo_word_06)})
      else $error("offset slope misassembled");

   chk_gslope_join: assert property (
      !$past(rst) |-> tcg_q == {$past(tc_hi_q[`CCFC_HI_B]), $past(lo_word_05)})
      else $error("gain slope misassembled");

   chk_tgain_unsigned: assert property (
      temp_gain_abs[IW-1:`CCFC_COEF_W] == '0 && temp_gain_abs[23:0] == tgain_q)
      else $error("temperature gain not zero-extended");

   chk_sign_extend: assert property (
      $signed(offset_coef) == $signed(off_q) && $signed(readout_quadratic) == $signed(readout_quadratic_q))
      else $error("signed coefficient not sign-extended");

   chk_first_gain: assert property (
      (wr_en && addr == `CCFC_W_CFG1 && wdata[`CCFC_G1_F] == 3'h7)
      ##1 !(wr_en && addr == `CCFC_W_CFG1) |=> front_amplifier_first_gain == 8'h78)
      else $error("first gain code 7 did not select 120");

   chk_second_gain: assert property (
      !$past(rst) |-> front_amplifier_second_gain == `CCFC_G2_BASE + {2'h0, $past(setup_q[`CCFC_G2_F])})
      else $error("second gain decode wrong");

   chk_abs_ground: assert property (
      !$past(rst) |-> negative_input_to_ground == $past(setup_q[`CCFC_ABS_B])
                      && single_ended_input_select == negative_input_to_ground)
      else $error("absolute input selection wrong");

   chk_res_range: assert property (
      !cfg_error |-> adc_res_bits >= `CCFC_RES_BASE && adc_res_bits <= `CCFC_RES_TOP)
      else $error("resolution outside 12 to 18 without error");

   chk_bad_res: assert property (
      (wr_en && addr == `CCFC_W_CFG1 && wdata[`CCFC_RES_F] == 4'h7)
      ##1 !(wr_en && addr == `CCFC_W_CFG1) |=> cfg_error && !conv_start)
      else $error("unassigned resolution not flagged");

   chk_reset_zero: assert property (
      $past(rst) |-> setup_q == '0 && sens_hi_q == '0 && tgain_hi_q == '0 && !cfg_error)
      else $error("state not zero after reset");

   chk_gslope_quad: assert property (
      !$past(rst) |-> gain_slope_quadratic_q == {$past(sot_hi_q[`CCFC_LO_B]), $past(lo_word_08)})
      else $error("gain slope quadratic misassembled");

   chk_zslope_quad: assert property (
      !$past(rst) |-> zero_slope_quadratic_q == {$past(sot_hi_q[`CCFC_HI_B]), $past(lo_word_07)})
      else $error("offset slope quadratic misassembled");

   chk_temp_offset: assert property (
      !$past(rst) |-> toff_q == {$past(tofs_hi_q[`CCFC_LO_B]), $past(lo_word_0a)})
      else $error("temperature offset misassembled");

   chk_readout_quad: assert property (
      !$past(rst) |-> readout_quadratic_q == {$past(tofs_hi_q[`CCFC_HI_B]), $past(lo_word_09)})
      else $error("readout quadratic misassembled");

   chk_temp_quad: assert property (
      !$past(rst) |-> temperature_quadratic_q == {$past(tgain_hi_q[`CCFC_LO_B]), $past(lo_word_0c)})
      else $error("temperature quadratic misassembled");

   chk_chop_polarity: assert property (
      !$past(rst) |-> chopper_polarity == $past(setup_q[`CCFC_POL_B]))
      else $error("chopper polarity not taken from setup word");

   chk_res_decode: assert property (
      !$past(rst) |-> adc_res_bits == `CCFC_RES_BASE + {1'b0, $past(setup_q[`CCFC_RES_F])})
      else $error("resolution decode wrong");

   chk_res_error: assert property (
      !$past(rst) |-> cfg_error == ($past(setup_q[`CCFC_RES_F]) > `CCFC_RES_MAX))
      else $error("resolution error flag wrong");

endmodule : ccfc_top

// ===== verification/ccfc_testbench.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the coefficient and setup word block
// Assumes: Word port protocol as in ccfc_top, outputs two edges after write
// Notes:   Low words are live inputs driven from a small array here
//----------------------------------------------------------------------
module testbench
   import ccfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int IW = 26;

   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic          wr_en = 1'b0;
   logic          rd_en = 1'b0;
   logic          conv_req = 1'b0;
   logic [7:0]    addr = 8'h00;
   ccfc_word_t    wdata = 16'h0000;
   ccfc_word_t    rdata;
   logic          rvalid;
   ccfc_word_t    lo [10];
   ccfc_word_t    hw [5];
   logic [IW-1:0] c_ofs, c_gain, c_zs, c_gs, c_gsq, c_zsq, c_tofs, c_rq, c_tq, c_tg;
   logic [7:0]    g1;
   logic [4:0]    g2, res;
   ccfc_pol_t     pol;
   logic          sel, gnd, cerr, cstart;
   int            failures = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   logic [7:0]    g1_tab [8] = '{8'h06, 8'h0C, 8'h14, 8'h1E, 8'h28, 8'h3C, 8'h50, 8'h78};

   always #5 sys_clk = ~sys_clk;

   ccfc_top #(.AW(8), .IW(IW)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
      .lo_word_03(lo[0]), .lo_word_04(lo[1]), .lo_word_05(lo[2]), .lo_word_06(lo[3]),
      .lo_word_07(lo[4]), .lo_word_08(lo[5]), .lo_word_09(lo[6]), .lo_word_0a(lo[7]),
      .lo_word_0b(lo[8]), .lo_word_0c(lo[9]),
      .offset_coef(c_ofs), .gain_coef(c_gain), .zero_slope_coef(c_zs),
      .gain_slope_coef(c_gs), .gain_slope_quadratic(c_gsq), .zero_slope_quadratic(c_zsq),
      .temp_offset_coef(c_tofs), .readout_quadratic(c_rq), .temperature_quadratic(c_tq),
      .temp_gain_abs(c_tg), .front_amplifier_first_gain(g1), .front_amplifier_second_gain(g2),
      .chopper_polarity(pol), .adc_res_bits(res), .single_ended_input_select(sel),
      .negative_input_to_ground(gnd), .cfg_error(cerr), .conv_req(conv_req),
      .conv_start(cstart)
   );

   //-------------------------------------------------------------------
   // Shared tasks
   //-------------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input ccfc_word_t d);
      tick(1);
      wr_en = 1'b1;
      addr  = a;
      wdata = d;
      tick(1);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input ccfc_word_t e);
      tick(1);
      rd_en = 1'b1;
      addr  = a;
      tick(1);
      rd_en = 1'b0;
      chk("rvalid", 32'h1, {31'h0, rvalid});
      chk($sformatf("word %h", a), {16'h0, e}, {16'h0, rdata});
   endtask : rd

   // Signed top byte over low word, extended by its sign into the wider path
   function automatic logic [31:0] sx(input logic [7:0] h, input ccfc_word_t l);
      return {{8{h[7]}}, h, l} & 32'h03FF_FFFF;
   endfunction : sx

   task automatic chk_coefs();
      chk("offset_coef", sx(hw[0][15:8], lo[0]), c_ofs);
      chk("gain_coef", sx(hw[0][7:0], lo[1]), c_gain);
      chk("zero_slope_coef", sx(hw[1][7:0], lo[3]), c_zs);
      chk("gain_slope_coef", sx(hw[1][15:8], lo[2]), c_gs);
      chk("gain_slope_quadratic", sx(hw[2][7:0], lo[5]), c_gsq);
      chk("zero_slope_quadratic", sx(hw[2][15:8], lo[4]), c_zsq);
      chk("temp_offset_coef", sx(hw[3][7:0], lo[7]), c_tofs);
      chk("readout_quadratic", sx(hw[3][15:8], lo[6]), c_rq);
      chk("temperature_quadratic", sx(hw[4][7:0], lo[9]), c_tq);
      chk("temp_gain_abs", {8'h0, hw[4][15:8], lo[8]}, c_tg);
   endtask : chk_coefs

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // Whole run needs well under a thousand cycles
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         $display("ERROR timeout expected done seen hang");
         wrap_up();
      end
   end

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < 10; i++)
         lo[i] = 16'h1357 + 16'h1111 * i[15:0];
      hw = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      tick(8);
      rst = 1'b0;
      tick(1);
      // Reset state
      for (int i = 0; i < 6; i++)
         rd(8'h0D + i[7:0], 16'h0000);
      chk("first gain", 32'h06, {24'h0, g1});
      chk("second gain", 32'h0B, {27'h0, g2});
      chk("res bits", 32'h0C, {27'h0, res});
      chk("cfg_error", 32'h0, {31'h0, cerr});
      chk_coefs();
      $display("Test reset done");
      // Coefficient assembly with both sign states in the top bytes
      hw = '{16'h817F, 16'h24C3, 16'hA55A, 16'h01FE, 16'h8090};
      for (int i = 0; i < 5; i++)
         wr(8'h0D + i[7:0], hw[i]);
      tick(1);
      chk_coefs();
      for (int i = 0; i < 10; i++)
         lo[i] = ~lo[i];
      tick(1);
      chk_coefs();
      for (int i = 0; i < 5; i++)
         rd(8'h0D + i[7:0], hw[i]);
      $display("Test coefficients done");
      // Setup word decode over every code
      for (int i = 0; i < 16; i++)
      begin
         wr(8'h12, {4'h0, i[1], i[3:0], i[0], ~i[2:0], i[2:0]});
         tick(1);
         conv_req = 1'b1;
         #1;
         chk("first gain", {24'h0, g1_tab[i[2:0]]}, {24'h0, g1});
         chk("second gain", 32'd18 - i[2:0], {27'h0, g2});
         chk("polarity", {31'h0, i[0]}, {31'h0, pol});
         chk("res bits", 32'd12 + i, {27'h0, res});
         chk("cfg_error", {31'h0, i > 6}, {31'h0, cerr});
         chk("conv_start", {31'h0, i <= 6}, {31'h0, cstart});
         chk("abs select", {31'h0, i[1]}, {31'h0, sel});
         chk("neg to ground", {31'h0, i[1]}, {31'h0, gnd});
         conv_req = 1'b0;
         #1;
         chk("conv idle", 32'h0, {31'h0, cstart});
      end
      rd(8'h12, 16'h0FC7);
      $display("Test setup decode done");
      // Unmapped places neither store nor disturb
      wr(8'h13, 16'hFFFF);
      wr(8'h0C, 16'hFFFF);
      rd(8'h13, 16'h0000);
      rd(8'h0C, 16'h0000);
      rd(8'h12, 16'h0FC7);
      rd(8'h0D, hw[0]);
      $display("Test unmapped done");
      wrap_up();
   end

endmodule : testbench
